/* File: hdl/amp_seq_defs.vh */
// Constants for the amplifier channel state sequencer.
// Assumes inclusion by bare name from design files under hdl/.
`ifndef AMP_SEQ_DEFS_VH
`define AMP_SEQ_DEFS_VH

// Channel state codes, shared by the command and report fields
`define ST_SHUTDOWN   3'h0
`define ST_DEEP_SLEEP 3'h1
`define ST_LOAD_DIAG  3'h2
`define ST_SLEEP      3'h3
`define ST_HIZ        3'h4
`define ST_PLAY       3'h5
`define ST_FAULT      3'h6
`define ST_RECOVERY   3'h7

// Device level states
`define DEV_SHUTDOWN  2'h0
`define DEV_PORST     2'h1
`define DEV_DEEP      2'h2
`define DEV_RUN       2'h3

// Reset values of configuration
`define CMD_RESET     3'h3
`define NUM_CH        4

`endif

/* File: hdl/sync2.v */
// Two-flop synchroniser for asynchronous pin levels.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter       W     = 1,
  parameter [0:0] RSTV  = 1'b0
) (
  input  wire         clk_in,
  input  wire         rst_b_in,
  input  wire [W-1:0] d_in,
  output wire [W-1:0] q_out
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] q_ff;

  // First stage feeds only the second
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      meta_ff <= {W{RSTV}};
      q_ff    <= {W{RSTV}};
    end else begin
      meta_ff <= d_in;
      q_ff    <= meta_ff;
    end
  end

  assign q_out = q_ff;
endmodule
`default_nettype wire

/* File: hdl/amp_channel_state_sequencer.v */
// Device and per-channel state sequencer for a four channel class-D amplifier.
// Assumes detector flags and host commands arrive as plain levels; pins and
// supply monitors are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "amp_seq_defs.vh"
module amp_channel_state_sequencer (
  input  wire        clk_in,
  input  wire        rst_b_in,
  // Pins and supply monitors (asynchronous)
  input  wire        power_down_n_pin_in,
  input  wire        standby_n_pin_in,
  input  wire        logic_supply_por_ok_in,
  input  wire        logic_supply_uv_in,
  input  wire        battery_uv_in,
  input  wire        power_stage_supply_ov_in,
  input  wire        power_stage_supply_uv_in,
  // Detector events (same clock)
  input  wire [3:0]  overcurrent_shutdown_in,
  input  wire [3:0]  dc_fault_in,
  input  wire [3:0]  load_current_fault_in,
  input  wire [3:0]  rt_diag_fault_in,
  input  wire [3:0]  channel_overtemp_shutdown_in,
  input  wire        overtemp_shutdown_in,
  input  wire        charge_pump_fault_in,
  input  wire        clock_error_in,
  input  wire [3:0]  diag_done_in,
  input  wire [3:0]  diag_fail_in,
  // Host configuration
  input  wire        cfg_write_in,
  input  wire [11:0] cfg_state_cmd_in,
  input  wire        cfg_ch_auto_recovery_in,
  input  wire        cfg_glob_auto_recovery_in,
  input  wire        cfg_power_fault_pin_en_in,
  input  wire        fault_mem_clear_in,
  // Status and controls
  output reg  [11:0] state_report_out,
  output reg  [3:0]  fault_mem_oc_out,
  output reg  [3:0]  fault_mem_dc_out,
  output reg  [3:0]  output_enable_out,
  output reg  [3:0]  diag_enable_out,
  output reg  [3:0]  rt_diag_allowed_out,
  output reg         dsp_enable_out,
  output reg         core_ldo_enable_out,
  output reg         analog_reg_enable_out,
  output reg         i2c_enable_out,
  output reg         regs_reset_out,
  output reg         fault_pin_n_out
);

  // ****************************************
  // Input synchronisation
  // ****************************************
  wire [6:0] raw_async = {power_down_n_pin_in, standby_n_pin_in, logic_supply_por_ok_in,
                          logic_supply_uv_in, battery_uv_in, power_stage_supply_ov_in,
                          power_stage_supply_uv_in};
  wire [6:0] syn;

  sync2 #(
    .W    (7),
    .RSTV (1'b0)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (raw_async),
    .q_out    (syn)
  );

  wire pwr_dn_n   = syn[6];
  wire standby_n  = syn[5];
  wire por_ok     = syn[4];
  wire logic_uv   = syn[3];
  wire battery_uv = syn[2];
  wire stage_ov   = syn[1];
  wire stage_uv   = syn[0];

  // Supply faults of the battery, power stage and logic supplies, cleared as soon as supply is nominal
  wire power_fault = battery_uv | stage_ov | stage_uv | logic_uv;
  // Global auto-recovery causes affecting every channel
  wire glob_recover = power_fault | clock_error_in
                    | (overtemp_shutdown_in & cfg_glob_auto_recovery_in);
  // Global latching causes
  wire glob_fault = (overtemp_shutdown_in & ~cfg_glob_auto_recovery_in)
                  | charge_pump_fault_in;

  // ****************************************
  // Device level state machine
  // ****************************************
  reg [1:0]  dev_ff;
  reg [1:0]  nxt_dev;

  // Shutdown holds for power-down or lost logic supply; reset pass precedes run
  always @* begin
    nxt_dev = dev_ff;
    if (!pwr_dn_n || !por_ok) begin
      nxt_dev = `DEV_SHUTDOWN;
    end else begin
      case (dev_ff)
        `DEV_SHUTDOWN: begin
          nxt_dev = `DEV_PORST;
        end
        `DEV_PORST: begin
          nxt_dev = standby_n ? `DEV_RUN : `DEV_DEEP;
        end
        `DEV_DEEP: begin
          if (standby_n) begin
            nxt_dev = `DEV_RUN;
          end
        end
        `DEV_RUN: begin
          if (!standby_n) begin
            nxt_dev = `DEV_DEEP;
          end
        end
        default: begin
          nxt_dev = `DEV_SHUTDOWN;
        end
      endcase
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      dev_ff <= `DEV_SHUTDOWN;
    end else begin
      dev_ff <= nxt_dev;
    end
  end

  // Defaults are restored only in shutdown and on the reset pass, so deep sleep keeps contents
  wire restore = (dev_ff == `DEV_SHUTDOWN) || (dev_ff == `DEV_PORST);
  wire running = (dev_ff == `DEV_RUN);

  // ****************************************
  // Host command register and fault memory
  // ****************************************
  reg [11:0] cmd_ff;
  reg [3:0]  oc_mem_ff;
  reg [3:0]  dc_mem_ff;

  // Command field survives deep sleep; set back to sleep only in shutdown and on reset pass
  always @(posedge clk_in) begin
    if (!rst_b_in || restore) begin
      cmd_ff    <= {`NUM_CH{`CMD_RESET}};
      oc_mem_ff <= 4'h0;
      dc_mem_ff <= 4'h0;
    end else begin
      if (cfg_write_in) begin
        cmd_ff <= cfg_state_cmd_in;
      end
      // Set wins over a simultaneous clear
      oc_mem_ff <= (oc_mem_ff & ~{4{fault_mem_clear_in}}) | overcurrent_shutdown_in;
      dc_mem_ff <= (dc_mem_ff & ~{4{fault_mem_clear_in}}) | dc_fault_in;
    end
  end

  // ****************************************
  // Per channel state machines
  // ****************************************
  reg [11:0] ch_ff;
  reg [11:0] nxt_ch;
  reg [11:0] prev_ff;
  reg [11:0] nxt_prev;
  reg [2:0]  cur;
  reg [2:0]  cmd;
  reg [2:0]  nst;
  reg [2:0]  pv;
  reg        ch_fault;
  reg        ch_rec;
  integer    i;

  always @* begin
    nxt_ch   = ch_ff;
    nxt_prev = prev_ff;
    cur      = 3'h0;
    cmd      = 3'h0;
    nst      = 3'h0;
    pv       = 3'h0;
    ch_fault = 1'b0;
    ch_rec   = 1'b0;
    for (i = 0; i < `NUM_CH; i = i + 1) begin
      cur = ch_ff[3*i +: 3];
      cmd = cmd_ff[3*i +: 3];
      pv  = prev_ff[3*i +: 3];
      nst = cur;
      // Fault causes per channel; detectors report, hardware decides
      ch_fault = overcurrent_shutdown_in[i] | dc_fault_in[i] | load_current_fault_in[i]
               | rt_diag_fault_in[i]
               | (channel_overtemp_shutdown_in[i] & ~cfg_ch_auto_recovery_in)
               | glob_fault;
      ch_rec   = (channel_overtemp_shutdown_in[i] & cfg_ch_auto_recovery_in) | glob_recover;
      // Next device state, so a stage never switches one cycle into standby
      if (nxt_dev == `DEV_SHUTDOWN || nxt_dev == `DEV_PORST) begin
        // Lost logic supply parks channels in sleep; shutdown is device wide
        nst = (!pwr_dn_n) ? `ST_SHUTDOWN : `ST_SLEEP;
      end else if (nxt_dev == `DEV_DEEP) begin
        nst = `ST_DEEP_SLEEP;
      end else begin
        case (cur)
          `ST_SHUTDOWN, `ST_DEEP_SLEEP: begin
            nst = `ST_SLEEP;
          end
          `ST_LOAD_DIAG: begin
            // Diagnostics run without audio clock; pass moves to sleep
            if (diag_fail_in[i]) begin
              nst = `ST_FAULT;
            end else if (diag_done_in[i]) begin
              nst = `ST_SLEEP;
            end
          end
          `ST_SLEEP: begin
            if (cmd == `ST_LOAD_DIAG) begin
              nst = `ST_LOAD_DIAG;
            end else if ((cmd == `ST_HIZ || cmd == `ST_PLAY) && !clock_error_in) begin
              nst = `ST_HIZ;
            end
          end
          `ST_HIZ, `ST_PLAY: begin
            if (ch_fault) begin
              nst = `ST_FAULT;
            end else if (ch_rec) begin
              nst = `ST_RECOVERY;
              nxt_prev[3*i +: 3] = cur;
            end else if (cmd == `ST_SLEEP || cmd == `ST_LOAD_DIAG) begin
              nst = `ST_SLEEP;
            end else if (cur == `ST_HIZ && cmd == `ST_PLAY) begin
              nst = `ST_PLAY;
            end else if (cur == `ST_PLAY && cmd == `ST_HIZ) begin
              nst = `ST_HIZ;
            end
          end
          `ST_FAULT: begin
            // Latched; host leaves it only by asking for sleep
            if (cmd == `ST_SLEEP && !ch_fault) begin
              nst = `ST_SLEEP;
            end
          end
          `ST_RECOVERY: begin
            if (ch_fault) begin
              nst = `ST_FAULT;
            end else if (!ch_rec) begin
              nst = (pv == `ST_HIZ) ? `ST_HIZ : `ST_PLAY;
            end
          end
          default: begin
            nst = `ST_SLEEP;
          end
        endcase
      end
      nxt_ch[3*i +: 3] = nst;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      ch_ff   <= {`NUM_CH{`ST_SHUTDOWN}};
      prev_ff <= {`NUM_CH{`ST_PLAY}};
    end else begin
      ch_ff   <= nxt_ch;
      prev_ff <= nxt_prev;
    end
  end

  // ****************************************
  // Output controls, all registered
  // ****************************************
  reg [3:0] nxt_oe;
  reg [3:0] nxt_diag;
  reg [3:0] nxt_rt;
  reg       nxt_dsp;
  integer   k;

  // Output stage only in play; everything else high impedance
  always @* begin
    nxt_oe   = 4'h0;
    nxt_diag = 4'h0;
    nxt_rt   = 4'h0;
    nxt_dsp  = 1'b0;
    for (k = 0; k < `NUM_CH; k = k + 1) begin
      nxt_oe[k]   = (nxt_ch[3*k +: 3] == `ST_PLAY);
      nxt_diag[k] = (nxt_ch[3*k +: 3] == `ST_LOAD_DIAG);
      nxt_rt[k]   = (nxt_ch[3*k +: 3] == `ST_PLAY);
      if (nxt_ch[3*k +: 3] == `ST_HIZ || nxt_ch[3*k +: 3] == `ST_PLAY) begin
        nxt_dsp = 1'b1;
      end
    end
    // DSP stays off whenever the logic supply sags
    if (logic_uv || nxt_dev != `DEV_RUN) begin
      nxt_dsp = 1'b0;
    end
  end

  // Fault pin, in run only: power faults when enabled; fault memories and overtemperature always; charge pump, clock, load and realtime never
  wire pin_fault = (|oc_mem_ff) | (|dc_mem_ff) | overtemp_shutdown_in
                 | (|channel_overtemp_shutdown_in)
                 | (power_fault & cfg_power_fault_pin_en_in);

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_report_out      <= {`NUM_CH{`ST_SHUTDOWN}};
      fault_mem_oc_out      <= 4'h0;
      fault_mem_dc_out      <= 4'h0;
      output_enable_out     <= 4'h0;
      diag_enable_out       <= 4'h0;
      rt_diag_allowed_out   <= 4'h0;
      dsp_enable_out        <= 1'b0;
      core_ldo_enable_out   <= 1'b0;
      analog_reg_enable_out <= 1'b0;
      i2c_enable_out        <= 1'b0;
      regs_reset_out        <= 1'b1;
      fault_pin_n_out       <= 1'b1;
    end else begin
      state_report_out      <= nxt_ch;
      fault_mem_oc_out      <= oc_mem_ff;
      fault_mem_dc_out      <= dc_mem_ff;
      output_enable_out     <= nxt_oe;
      diag_enable_out       <= nxt_diag;
      rt_diag_allowed_out   <= nxt_rt;
      dsp_enable_out        <= nxt_dsp;
      // Core regulator lives outside shutdown; control interface only in run and deep sleep
      core_ldo_enable_out   <= (nxt_dev != `DEV_SHUTDOWN);
      analog_reg_enable_out <= (nxt_dev == `DEV_RUN);
      i2c_enable_out        <= (nxt_dev == `DEV_RUN) || (nxt_dev == `DEV_DEEP);
      regs_reset_out        <= (nxt_dev == `DEV_SHUTDOWN) || (nxt_dev == `DEV_PORST);
      fault_pin_n_out       <= ~(pin_fault & running);
    end
  end

endmodule
`default_nettype wire

/* File: tb/amp_seq_asserts.sv */
// Checker for the channel state sequencer, bound to its top module.
// Assumes hdl/ on the include path for the state codes.
`timescale 1ns/1ps
`default_nettype none
`include "amp_seq_defs.vh"
module amp_seq_asserts (
  input wire logic        clk_in, rst_b_in, power_down_n_pin_in, standby_n_pin_in,
  input wire logic        logic_supply_por_ok_in, overtemp_shutdown_in, clock_error_in,
  input wire logic        cfg_power_fault_pin_en_in, dsp_enable_out, core_ldo_enable_out,
  input wire logic        analog_reg_enable_out, i2c_enable_out, fault_pin_n_out,
  input wire logic [3:0]  overcurrent_shutdown_in, dc_fault_in, channel_overtemp_shutdown_in,
  input wire logic [3:0]  diag_done_in, diag_fail_in, fault_mem_oc_out, fault_mem_dc_out,
  input wire logic [3:0]  output_enable_out, diag_enable_out, rt_diag_allowed_out,
  input wire logic [11:0] state_report_out
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Pin passes two sync flops before the state register
  pd_off_a: assert property (!power_down_n_pin_in [*4] |-> state_report_out == 12'h000
    && !core_ldo_enable_out && !analog_reg_enable_out) else $error("power-down not honoured");
  deep_sleep_a: assert property ((power_down_n_pin_in && !standby_n_pin_in && logic_supply_por_ok_in) [*8]
    |-> core_ldo_enable_out && i2c_enable_out && !dsp_enable_out && !analog_reg_enable_out
    && output_enable_out == 4'h0) else $error("standby state wrong");
  oc_fault_a: assert property (output_enable_out[0] && overcurrent_shutdown_in[0] |-> ##[1:2]
    state_report_out[2:0] == `ST_FAULT && !output_enable_out[0]) else $error("overcurrent not to fault");
  dc_memory_a: assert property (output_enable_out[0] && dc_fault_in[0]
    |-> ##2 fault_mem_dc_out[0]) else $error("dc fault not latched");
  clk_err_a: assert property (output_enable_out[2] && clock_error_in ##1 clock_error_in
    |-> ##1 state_report_out[8:6] == `ST_RECOVERY && !output_enable_out[2]) else $error("no recovery state");
  rec_back_a: assert property ($fell(clock_error_in) && state_report_out[8:6] == `ST_RECOVERY
    && !overtemp_shutdown_in |-> ##[1:3] state_report_out[8:6] inside {`ST_PLAY, `ST_HIZ})
    else $error("no return after clock error");
  sleep_hold_a: assert property (state_report_out[2:0] == `ST_SLEEP && clock_error_in
    |=> state_report_out[2:0] != `ST_HIZ) else $error("left sleep under clock error");
  play_ctl_a: assert property (output_enable_out[3] |-> rt_diag_allowed_out[3]
    && dsp_enable_out && state_report_out[11:9] == `ST_PLAY) else $error("output on outside play");
  diag_pass_a: assert property (state_report_out[5:3] == `ST_LOAD_DIAG && diag_done_in[1]
    && !diag_fail_in[1] |-> ##[1:2] state_report_out[5:3] == `ST_SLEEP) else $error("diag pass stuck");
  // Diagnostics must never overlap a switching stage
  diag_off_a: assert property (diag_enable_out != 4'h0 |-> (diag_enable_out & output_enable_out) == 4'h0
    ##1 (output_enable_out & $past(diag_enable_out)) == 4'h0) else $error("stage on during diag");
  pin_mask_a: assert property ((!cfg_power_fault_pin_en_in && fault_mem_oc_out == 4'h0
    && fault_mem_dc_out == 4'h0 && !overtemp_shutdown_in && channel_overtemp_shutdown_in == 4'h0) [*3]
    |-> fault_pin_n_out) else $error("masked fault on pin");
  cover property (clock_error_in && output_enable_out != 4'h0);
  cover property (diag_enable_out != 4'h0);
  cover property (!fault_pin_n_out);
endmodule
bind amp_channel_state_sequencer amp_seq_asserts u_chk (.*);
`default_nettype wire

/* File: tb/host_model.sv */
// Host side model: writes channel state commands and clears fault memory.
// Assumes the bench calls its tasks at a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        clk_in,
  output var  logic        cfg_write_in,
  output var  logic [11:0] cfg_state_cmd_in,
  output var  logic        fault_mem_clear_in
);
  // ****************
  // Host accesses
  // ****************
  initial begin
    cfg_write_in = 1'b0;
    cfg_state_cmd_in = 12'h000;
    fault_mem_clear_in = 1'b0;
  end
  // Command word scrambled after the strobe so stale data is never relied on
  task automatic send(input logic [11:0] cmd);
    cfg_write_in = 1'b1;
    cfg_state_cmd_in = cmd;
    @(negedge clk_in);
    cfg_write_in = 1'b0;
    cfg_state_cmd_in = ~cmd;
    @(negedge clk_in);
  endtask
  task automatic clear_mem;
    fault_mem_clear_in = 1'b1;
    @(negedge clk_in);
    fault_mem_clear_in = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Bench for the channel state sequencer: host model plus pin and event stimulus.
// Assumes hdl/ on the include path and the checker bound separately.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****************
  // Wiring
  // ****************
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        power_down_n_pin_in = 1'b1;
  logic        standby_n_pin_in = 1'b1;
  logic        logic_supply_por_ok_in = 1'b1;
  logic        overtemp_shutdown_in = 1'b0;
  logic        charge_pump_fault_in = 1'b0;
  logic        clock_error_in = 1'b0;
  logic        cfg_ch_auto_recovery_in = 1'b0;
  logic        cfg_glob_auto_recovery_in = 1'b0;
  logic        cfg_power_fault_pin_en_in = 1'b0;
  logic [3:0]  sup = 4'h0;  // Logic uv, battery uv, stage ov, stage uv
  logic [15:0] chf = 16'h0; // Realtime, load, dc, overcurrent per channel
  logic [3:0]  channel_overtemp_shutdown_in = 4'h0;
  logic [3:0]  diag_done_in = 4'h0;
  logic [3:0]  diag_fail_in = 4'h0;
  wire         cfg_write_in, fault_mem_clear_in, dsp_enable_out, core_ldo_enable_out;
  wire         analog_reg_enable_out, i2c_enable_out, regs_reset_out, fault_pin_n_out;
  wire  [11:0] cfg_state_cmd_in, state_report_out;
  wire  [3:0]  fault_mem_oc_out, fault_mem_dc_out, output_enable_out, diag_enable_out, rt_diag_allowed_out;
  int          n_fail = 0;
  int          comparisons = 0;
  localparam logic [11:0] SLP = 12'h6DB, PLY = 12'hB6D, AUT = 12'hFFF, FLT = 12'hDB6;
  localparam logic [11:0] EV_EXP [5] = '{AUT, FLT, FLT, 12'hF6D, 12'hD6D};
  always #12.5 clk_in = ~clk_in;
  amp_channel_state_sequencer u_dut (
    .logic_supply_uv_in       (sup[3]),
    .battery_uv_in            (sup[2]),
    .power_stage_supply_ov_in (sup[1]),
    .power_stage_supply_uv_in (sup[0]),
    .overcurrent_shutdown_in  (chf[3:0]),
    .dc_fault_in              (chf[7:4]),
    .load_current_fault_in    (chf[11:8]),
    .rt_diag_fault_in         (chf[15:12]),
    .*
  );
  host_model u_host (.*);
  // ****************
  // Helpers
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Whole run is a few hundred cycles; this leaves ample margin
  initial begin
    #20us;
    n_fail++;
    conclude();
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    cyc(6);
    chk({regs_reset_out, fault_pin_n_out, state_report_out}, 14'h3000);
    rst_b_in = 1'b1;
    cyc(10);
    chk(state_report_out, SLP);
    chk(regs_reset_out, 1'b0);
    u_host.send(PLY);
    cyc(3);
    chk(state_report_out, PLY);
    chk({dsp_enable_out, output_enable_out, rt_diag_allowed_out}, 9'h1FF);
    // Each per-channel fault kind on channel 0, then back to play
    for (int i = 0; i < 4; i++) begin
      chf = 16'h1 << (4 * i);
      cyc(1);
      chf = 16'h0;
      cyc(2);
      chk({state_report_out, output_enable_out}, {12'hB6E, 4'hE});
      chk({fault_mem_dc_out, fault_mem_oc_out}, (i < 2) ? 8'h01 << (4 * i) : 8'h00);
      chk(fault_pin_n_out, i > 1);
      u_host.clear_mem();
      u_host.send(12'hB6B);
      u_host.send(PLY);
      chk({fault_mem_dc_out, fault_mem_oc_out}, 8'h00);
      cyc(3);
      chk(state_report_out, PLY);
    end
    // Supply faults, pin reporting alternately enabled
    for (int i = 0; i < 4; i++) begin
      cfg_power_fault_pin_en_in = i[0];
      sup = 4'h1 << i;
      cyc(5);
      chk(state_report_out, AUT);
      chk({dsp_enable_out, fault_pin_n_out}, {1'b0, ~i[0]});
      sup = 4'h0;
      cyc(6);
      chk(state_report_out, PLY);
    end
    cfg_power_fault_pin_en_in = 1'b0;
    // Clock error holds a sleeping channel back
    u_host.send(12'hB6B);
    clock_error_in = 1'b1;
    u_host.send(PLY);
    cyc(2);
    chk(state_report_out, 12'hFFB);
    clock_error_in = 1'b0;
    cyc(5);
    chk(state_report_out, PLY);
    // Recovery returns a Hi-Z channel to Hi-Z, then play by command
    u_host.send(12'h924);
    cyc(1);
    chk(state_report_out, 12'h924);
    clock_error_in = 1'b1;
    cyc(2);
    chk(state_report_out, AUT);
    clock_error_in = 1'b0;
    cyc(2);
    chk(state_report_out, 12'h924);
    u_host.send(PLY);
    cyc(2);
    chk(state_report_out, PLY);
    // Global and channel overtemperature, charge pump
    for (int k = 0; k < 5; k++) begin
      cfg_glob_auto_recovery_in = (k == 0);
      cfg_ch_auto_recovery_in = (k == 3);
      {channel_overtemp_shutdown_in[3], charge_pump_fault_in, overtemp_shutdown_in} = {k > 2, k == 2, k < 2};
      cyc(3);
      chk(state_report_out, EV_EXP[k]);
      chk(fault_pin_n_out, k == 2);
      {channel_overtemp_shutdown_in[3], charge_pump_fault_in, overtemp_shutdown_in} = 3'h0;
      cyc(2);
      u_host.send(SLP);
      u_host.send(PLY);
      cyc(3);
      chk(state_report_out, PLY);
    end
    // Load diagnostics on channel 1: fail, then pass
    u_host.send(SLP);
    u_host.send(12'h6D3);
    cyc(1);
    chk({diag_enable_out, output_enable_out}, 8'h20);
    diag_fail_in = 4'h2;
    cyc(1);
    diag_fail_in = 4'h0;
    cyc(2);
    chk(state_report_out, 12'h6F3);
    u_host.send(SLP);
    u_host.send(12'h6D3);
    diag_done_in = 4'h2;
    u_host.send(SLP);
    diag_done_in = 4'h0;
    cyc(1);
    chk(state_report_out, SLP);
    // Standby, logic supply loss, power-down
    u_host.send(PLY);
    cyc(3);
    standby_n_pin_in = 1'b0;
    cyc(8);
    chk(state_report_out, 12'h249);
    chk({core_ldo_enable_out, i2c_enable_out, analog_reg_enable_out, dsp_enable_out, output_enable_out}, 8'hC0);
    standby_n_pin_in = 1'b1;
    cyc(12);
    chk(state_report_out, PLY);
    logic_supply_por_ok_in = 1'b0;
    cyc(5);
    chk({state_report_out, i2c_enable_out, dsp_enable_out}, {SLP, 2'h0});
    logic_supply_por_ok_in = 1'b1;
    cyc(10);
    chk(state_report_out, SLP);
    u_host.send(PLY);
    cyc(3);
    power_down_n_pin_in = 1'b0;
    cyc(5);
    chk({state_report_out, core_ldo_enable_out, analog_reg_enable_out}, 14'h0);
    chk(regs_reset_out, 1'b1);
    power_down_n_pin_in = 1'b1;
    cyc(10);
    chk(state_report_out, SLP);
    conclude();
  end
endmodule
`default_nettype wire
